//--- design/arf_bank.sv
// Serial register bank of the converter with its output rate generator.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - The registers are reached only through the serial port.
// R2 - Every access starts with an 8-bit write of the command register.
// R3 - The command byte picks read or write and the target register.
// R4 - After a transfer the port waits for a command, except in continuous read.
// R5 - The 8-bit status register resets its top nibble to c and shows state.
// R6 - The result register holds the newest conversion and resets to zero.
// R7 - The result is read as 16 or 24 bits as the word-length bit says.
// R8 - The 16-bit mode register resets to 01b0 and steers the converter.
// R9 - The mode low byte holds reference, zero, range, clock-out, burnout, channel.
// R10 - The 24-bit filter register resets to 200010.
// R11 - The output rate comes from the 12-bit rate field, slower as it grows.
// R12 - With chop enable clear the input path is not chopped.
// R13 - Without chop a rate field of 2048 gives 150 Hz from a 4.9152 MHz clock.
// R14 - After reset the port waits for a command byte.
// R15 - Thirty-two serial clocks with data in high reset the block.
// R16 - Writes to read-only registers and reads of the command register do nothing.
module arf_bank #(
  parameter int MCLK_DIV = 51
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic din,
  input wire logic cs_n,
  input wire logic ref_missing_pin,
  input wire logic [23:0] conv_sample,
  output logic dout,
  output logic data_ready_n,
  output logic chop_active,
  output logic conv_strobe,
  output arf_pkg::arf_opctl_s opctl_out
);
  import arf_pkg::*;

  // The prescaler counter is eight bits wide, so the divider must fit it.
  if (MCLK_DIV < 1 || MCLK_DIV > 255)
  begin : g_div_check
    $error("MCLK_DIV out of range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_q1;
  logic [3:0] pin_q2;
  logic sclk_q3;
  wire sclk_s = pin_q2[0];
  wire din_s = pin_q2[1];
  wire sel_s = ~pin_q2[2];
  wire ref_missing_s = pin_q2[3];
  wire sclk_rise = sel_s & sclk_s & ~sclk_q3;
  wire sclk_fall = sel_s & ~sclk_s & sclk_q3;

  // Two flops on every pin before any logic reads it.
  always_ff @(posedge ref_clk)
  begin
    pin_q1 <= {ref_missing_pin, cs_n, din, sclk}; // R1
    pin_q2 <= pin_q1;
    sclk_q3 <= pin_q2[0];
  end

  // ----------------------------------------------------------------
  // Registers and serial state
  // ----------------------------------------------------------------
  arf_opctl_s opctl;
  arf_filter_s filter;
  arf_state_e state;
  logic [23:0] result;
  logic [2:0] sel;
  logic cont_read;
  logic [4:0] bit_cnt;
  logic [4:0] len;
  logic [23:0] sh_in;
  logic [23:0] sh_out;
  logic [5:0] ones_cnt;
  logic settled;
  logic [7:0] mclk_cnt;
  logic [17:0] conv_cnt;

  // Word assembly and completion of a transfer on a rising serial edge.
  wire [23:0] next_word = {sh_in[22:0], din_s};
  wire arf_cmd_s next_cmd = arf_cmd_s'(next_word[7:0]);
  wire [2:0] cmd_sel = {next_cmd.reg_sel_2, next_cmd.reg_sel_1,
                        next_cmd.reg_sel_0};
  wire [1:0] cmd_acc = {next_cmd.access_type_hi, next_cmd.access_type_lo};
  wire last_bit = sclk_rise & (bit_cnt + 5'h01 == len);
  wire soft_rst = sclk_rise & din_s & (ones_cnt == ONES_FOR_RESET - 6'h01);
  wire any_rst = rst | soft_rst; // R15
  wire cmd_done = last_bit & (state == ST_CMD) & ~next_cmd.write_enable_n;
  wire wr_done = last_bit & (state == ST_WRITE);
  wire rd_done = last_bit & (state == ST_READ);
  wire cont_stay = rd_done & cont_read & (next_word[7:0] != CMD_CONT_STOP);

  // Width of the selected register on the wire.
  function automatic logic [4:0] reg_len(input logic [2:0] s,
                                         input logic wl);
    case (s)
      SEL_RESULT: reg_len = wl ? LEN_FULL : LEN_HALF; // R7
      SEL_OPCTL: reg_len = LEN_HALF;
      SEL_FILTER: reg_len = LEN_FULL;
      default: reg_len = LEN_BYTE;
    endcase
  endfunction

  // Read data, left aligned so the first bit out is bit 23.
  wire [7:0] state_word = {data_ready_n, settled,
                           opctl.op_mode == OPM_STANDBY, ref_missing_s,
                           1'b0, opctl.op_mode}; // R5

  // Next read word depends on the register just named.
  wire [2:0] rd_sel = cmd_done ? cmd_sel : sel;
  wire [23:0] ld_word =
    (rd_sel == SEL_STATE) ? {state_word, 16'h0000} :
    (rd_sel == SEL_RESULT) ? result :
    (rd_sel == SEL_OPCTL) ? {opctl, 8'h00} :
    (rd_sel == SEL_FILTER) ? filter :
    24'h000000; // R16
  wire rd_load = (cmd_done & (cmd_acc == ACC_READ ||
                              cmd_acc == ACC_CONT_START)) | cont_stay;

  // ----------------------------------------------------------------
  // Serial transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (any_rst)
    begin
      state <= ST_CMD; // R14
      sel <= SEL_COMMAND;
      cont_read <= 1'b0;
      bit_cnt <= 5'h00;
      len <= LEN_BYTE;
      sh_in <= 24'h000000;
      sh_out <= 24'h000000;
      dout <= 1'b0;
    end
    else
    begin
      if (sclk_rise)
      begin
        sh_in <= next_word;
        bit_cnt <= last_bit ? 5'h00 : bit_cnt + 5'h01;
      end
      // The word is only staged here; its top bit goes out on the next
      // falling serial edge, so the host sees every bit at its rising edge.
      if (rd_load)
        sh_out <= ld_word; // R7
      else if (sclk_fall && state == ST_READ)
      begin
        dout <= sh_out[23];
        sh_out <= {sh_out[22:0], 1'b0};
      end
      if (cmd_done) // R2
      begin
        sel <= cmd_sel; // R3
        len <= reg_len(cmd_sel, opctl.result_word_length);
        case (cmd_acc)
          ACC_WRITE: state <= ST_WRITE;
          ACC_READ: state <= ST_READ;
          ACC_CONT_START: state <= ST_READ;
          default: state <= ST_CMD;
        endcase
        cont_read <= (cmd_acc == ACC_CONT_START);
      end
      else if (wr_done || (rd_done && !cont_stay))
      begin
        state <= ST_CMD; // R4
        len <= LEN_BYTE;
        cont_read <= 1'b0;
      end
    end
  end

  // Run of ones on data in while the serial clock ticks.
  always_ff @(posedge ref_clk)
  begin
    if (any_rst)
      ones_cnt <= 6'h00;
    else if (sclk_rise)
      ones_cnt <= din_s ? ones_cnt + 6'h01 : 6'h00; // R15
  end

  // ----------------------------------------------------------------
  // Output rate generator
  // ----------------------------------------------------------------
  wire [5:0] per_sf = filter.chop_enable ? MCLK_PER_SF_CHOP
                                         : MCLK_PER_SF_NOCHOP; // R12
  wire [17:0] period = 18'(filter.rate_select_field * per_sf); // R11 R13
  wire mclk_tick = (mclk_cnt == 8'(MCLK_DIV - 1));
  wire converting = (opctl.op_mode == OPM_CONTINUOUS) ||
                    (opctl.op_mode == OPM_SINGLE);
  wire conv_tick = converting & mclk_tick & (conv_cnt + 18'h1 >= period);

  // Master clock prescaler and conversion period counter.
  always_ff @(posedge ref_clk)
  begin
    if (any_rst)
    begin
      mclk_cnt <= 8'h00;
      conv_cnt <= 18'h00000;
    end
    else
    begin
      mclk_cnt <= mclk_tick ? 8'h00 : mclk_cnt + 8'h01;
      if (!converting || conv_tick)
        conv_cnt <= 18'h00000;
      else if (mclk_tick)
        conv_cnt <= conv_cnt + 18'h1;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  wire rd_result = rd_done & (sel == SEL_RESULT);

  // Host writes, conversion results and status flags.
  always_ff @(posedge ref_clk)
  begin
    if (any_rst)
    begin
      opctl <= arf_opctl_s'(OPCTL_RESET); // R8
      filter <= arf_filter_s'(FILTER_RESET); // R10
      result <= RESULT_RESET; // R6
      data_ready_n <= STATE_HI_RESET[3];
      settled <= STATE_HI_RESET[2];
      chop_active <= FILTER_RESET[4];
      conv_strobe <= 1'b0;
      opctl_out <= arf_opctl_s'(OPCTL_RESET);
    end
    else
    begin
      if (wr_done && sel == SEL_OPCTL)
        opctl <= arf_opctl_s'(next_word[15:0]); // R8 R9
      else if (conv_tick && opctl.op_mode == OPM_SINGLE)
        opctl.op_mode <= OPM_IDLE;
      if (wr_done && sel == SEL_FILTER)
        filter <= arf_filter_s'(next_word); // R10
      if (conv_tick)
        result <= conv_sample; // R6
      // A new result wins over the clear caused by reading the old one.
      if (conv_tick)
        data_ready_n <= 1'b0;
      else if (rd_result)
        data_ready_n <= 1'b1;
      // A conversion in the same cycle as a setting write still sets it.
      if (conv_tick)
        settled <= 1'b1;
      else if (wr_done && (sel == SEL_OPCTL || sel == SEL_FILTER))
        settled <= 1'b0;
      chop_active <= filter.chop_enable; // R12
      conv_strobe <= conv_tick;
      opctl_out <= opctl;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ready_on_result: assert property (@(posedge ref_clk) disable iff (rst) // R6
    conv_tick && !soft_rst |=> !data_ready_n && result == $past(conv_sample))
    else $error("result or ready not updated after conversion");
  chk_result_len: assert property (@(posedge ref_clk) disable iff (rst) // R7
    cmd_done && cmd_sel == SEL_RESULT && !opctl.result_word_length |=>
    len == 5'h10)
    else $error("result length not 16 bits");
  chk_back_to_cmd: assert property (@(posedge ref_clk) disable iff (rst) // R4
    wr_done || (rd_done && !cont_read) |=> state == ST_CMD)
    else $error("port did not return to command wait");
  chk_ones_reset: assert property (@(posedge ref_clk) disable iff (rst) // R15
    soft_rst |=> opctl == arf_opctl_s'(OPCTL_RESET) && state == ST_CMD)
    else $error("ones run did not reset");
  chk_reset_wait: assert property (@(posedge ref_clk) // R14
    rst |=> state == ST_CMD && filter == arf_filter_s'(FILTER_RESET))
    else $error("not in command wait after reset");
  chk_ro_ignored: assert property (@(posedge ref_clk) disable iff (rst) // R16
    wr_done && sel == SEL_STATE && !soft_rst |=>
    $stable(opctl) && $stable(filter))
    else $error("write to read-only register changed state");
  chk_chop_follow: assert property (@(posedge ref_clk) disable iff (rst) // R12
    !filter.chop_enable && !soft_rst |=> !chop_active)
    else $error("chop output active with chop disabled");
  chk_period_len: assert property (@(posedge ref_clk) disable iff (rst) // R11
    conv_tick |-> conv_cnt + 18'h1 >= period && mclk_tick)
    else $error("conversion before period elapsed");
  chk_cmd_needed: assert property (@(posedge ref_clk) disable iff (rst) // R2
    state == ST_CMD && !cmd_done |=> state == ST_CMD)
    else $error("transfer started without command");

endmodule

//--- design/arf_pkg.sv
// Package for the converter register bank: field layouts, resets, timing.
package arf_pkg;

  // ----------------------------------------------------------------
  // Register select codes and access types
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_COMMAND = 3'h0;
  localparam logic [2:0] SEL_STATE = 3'h1;
  localparam logic [2:0] SEL_RESULT = 3'h2;
  localparam logic [2:0] SEL_OPCTL = 3'h3;
  localparam logic [2:0] SEL_FILTER = 3'h4;
  localparam logic [1:0] ACC_WRITE = 2'h0;
  localparam logic [1:0] ACC_READ = 2'h1;
  localparam logic [1:0] ACC_CONT_START = 2'h2;
  localparam logic [1:0] ACC_CONT_STOP = 2'h3;
  localparam logic [7:0] CMD_CONT_STOP = 8'h30;

  // ----------------------------------------------------------------
  // Reset values and field widths
  // ----------------------------------------------------------------
  localparam logic [15:0] OPCTL_RESET = 16'h01b0;
  localparam logic [23:0] FILTER_RESET = 24'h200010;
  localparam logic [23:0] RESULT_RESET = 24'h000000;
  localparam logic [3:0] STATE_HI_RESET = 4'hc;
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_HALF = 5'h10;
  localparam logic [4:0] LEN_FULL = 5'h18;
  localparam logic [5:0] ONES_FOR_RESET = 6'h20;
  localparam logic [5:0] MCLK_PER_SF_NOCHOP = 6'h10;
  localparam logic [5:0] MCLK_PER_SF_CHOP = 6'h30;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  localparam logic [2:0] OPM_IDLE = 3'h0;
  localparam logic [2:0] OPM_CONTINUOUS = 3'h1;
  localparam logic [2:0] OPM_SINGLE = 3'h2;
  localparam logic [2:0] OPM_STANDBY = 3'h3;

  // Command byte, first bit on the wire at the top.
  typedef struct packed {
    logic write_enable_n;
    logic zero_a;
    logic access_type_hi;
    logic access_type_lo;
    logic zero_b;
    logic reg_sel_2;
    logic reg_sel_1;
    logic reg_sel_0;
  } arf_cmd_s;

  // Operating control register layout.
  typedef struct packed {
    logic [2:0] op_mode;
    logic bipolar_n;
    logic digital_pin_enable;
    logic digital_pin_level_1;
    logic digital_pin_level_0;
    logic result_word_length;
    logic reference_level_select;
    logic zero_c;
    logic [1:0] input_range;
    logic clock_out_disable;
    logic burnout_current_enable;
    logic [1:0] channel_sel;
  } arf_opctl_s;

  // Filter control register layout.
  typedef struct packed {
    logic [11:0] rate_select_field;
    logic [1:0] zero_d;
    logic skip;
    logic fast;
    logic [1:0] zero_e;
    logic ac_excite;
    logic chop_enable;
    logic [3:0] delay_sel;
  } arf_filter_s;

  typedef enum logic [1:0] {ST_CMD, ST_WRITE, ST_READ} arf_state_e;

endpackage

//--- bench/arf_host.sv
// Host model that drives the serial port of the register bank.
`timescale 1ns/1ps
module arf_host #(
  parameter int HALF = 6
) (
  input wire logic ref_clk,
  input wire logic dout,
  output logic sclk,
  output logic din,
  output logic cs_n
);
  // The port starts deselected, with the serial clock standing high.
  initial
  begin
    sclk = 1'b1;
    din = 1'b0;
    cs_n = 1'b1;
  end

  // Sends the low n bits of tx, top bit first. dout is sampled just
  // before each rising edge, once it has settled after the fall.
  task automatic xfer(input logic [31:0] tx, input int n,
    output logic [31:0] rx);
    rx = '0;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge ref_clk);
      sclk <= 1'b0;
      din <= tx[i];
      repeat (HALF) @(posedge ref_clk);
      rx = {rx[30:0], dout};
      sclk <= 1'b1;
      repeat (HALF) @(posedge ref_clk);
    end
    cs_n <= 1'b1;
    // A released data line must not keep showing the last bit.
    din <= ~din;
  endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the converter register bank.
`timescale 1ns/1ps
module testbench;
  import arf_pkg::*;
  logic ref_clk;
  logic rst;
  logic sclk;
  logic din;
  logic cs_n;
  logic ref_missing_pin;
  logic [23:0] conv_sample;
  logic dout;
  logic data_ready_n;
  logic chop_active;
  logic conv_strobe;
  arf_opctl_s opctl_out;
  int mismatches;
  int compares;
  int n;
  logic [31:0] rx;

  // The design, with one reference clock per master tick.
  arf_bank #(.MCLK_DIV(1)) arf_bank_inst (.ref_clk(ref_clk), .rst(rst),
    .sclk(sclk), .din(din), .cs_n(cs_n),
    .ref_missing_pin(ref_missing_pin), .conv_sample(conv_sample),
    .dout(dout), .data_ready_n(data_ready_n), .chop_active(chop_active),
    .conv_strobe(conv_strobe), .opctl_out(opctl_out));
  arf_host arf_host_inst (.ref_clk(ref_clk), .dout(dout), .sclk(sclk),
    .din(din), .cs_n(cs_n));

  // A 250 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One command byte followed by len data bits in a single frame.
  task automatic access(input logic [1:0] acc, input logic [2:0] sel,
    input int len, input logic [23:0] val);
    logic [31:0] tx;
    tx = ({24'h0, 2'b00, acc, 1'b0, sel} << len) | 32'(val);
    arf_host_inst.xfer(tx, 8 + len, rx);
    rx = rx & ((32'h1 << len) - 32'h1);
  endtask

  // Counts reference clocks from one conversion strobe to the next.
  task automatic period();
    n = 0;
    while (conv_strobe !== 1'b1 && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    n = 1;
    while (conv_strobe !== 1'b1 && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic t_reset();
    check(32'(opctl_out), 32'(OPCTL_RESET));
    check(32'(chop_active), 32'h1);
    check(32'(data_ready_n), 32'h1);
    access(ACC_READ, SEL_STATE, 8, 24'h0);
    check(rx, {24'h0, STATE_HI_RESET, 4'h0});
    access(ACC_READ, SEL_OPCTL, 16, 24'h0);
    check(rx, 32'(OPCTL_RESET));
    access(ACC_READ, SEL_FILTER, 24, 24'h0);
    check(rx, 32'(FILTER_RESET));
    access(ACC_READ, SEL_RESULT, 24, 24'h0);
    check(rx, 32'(RESULT_RESET));
    $display("test reset done");
  endtask

  task automatic t_regs();
    access(ACC_WRITE, SEL_OPCTL, 16, 24'h1aa9);
    access(ACC_WRITE, SEL_FILTER, 24, 24'h004000);
    repeat (4) @(posedge ref_clk);
    check(32'(opctl_out), 32'h1aa9);
    check(32'(opctl_out.input_range), 32'h2);
    check(32'(opctl_out.channel_sel), 32'h1);
    check(32'(chop_active), 32'h0);
    access(ACC_READ, SEL_FILTER, 24, 24'h0);
    check(rx, 32'h004000);
    access(ACC_WRITE, SEL_STATE, 8, 24'hff);
    access(ACC_WRITE, SEL_RESULT, 24, 24'hffffff);
    access(ACC_READ, SEL_STATE, 8, 24'h0);
    check(rx, 32'h80);
    access(ACC_READ, SEL_RESULT, 16, 24'h0);
    check(rx, 32'h0);
    access(ACC_READ, SEL_COMMAND, 8, 24'h0);
    check(rx, 32'h0);
    arf_host_inst.xfer(32'h93, 8, rx);
    access(ACC_READ, SEL_OPCTL, 16, 24'h0);
    check(rx, 32'h1aa9);
    access(ACC_WRITE, SEL_OPCTL, 16, 24'h7aa9);
    access(ACC_READ, SEL_STATE, 8, 24'h0);
    check(rx, 32'ha3);
    $display("test registers done");
  endtask

  task automatic t_rate();
    logic [23:0] flt [3];
    int exp [3];
    flt = '{24'h002000, 24'h004000, 24'h004010};
    exp = '{32, 64, 192};
    ref_missing_pin <= 1'b1;
    conv_sample <= 24'habcdef;
    access(ACC_WRITE, SEL_OPCTL, 16, 24'h3aa9);
    for (int i = 0; i < 3; i++)
    begin
      access(ACC_WRITE, SEL_FILTER, 24, flt[i]);
      period();
      period();
      check(32'(n), 32'(exp[i]));
    end
    access(ACC_READ, SEL_STATE, 8, 24'h0);
    check(rx & 32'h57, 32'h51);
    $display("test rate done");
  endtask

  task automatic t_result();
    access(ACC_WRITE, SEL_OPCTL, 16, 24'h5aa9);
    period();
    repeat (4) @(posedge ref_clk);
    check(32'(data_ready_n), 32'h0);
    check(32'(opctl_out.op_mode), 32'(OPM_IDLE));
    access(ACC_READ, SEL_RESULT, 16, 24'h0);
    check(rx, 32'habcd);
    check(32'(data_ready_n), 32'h1);
    access(ACC_WRITE, SEL_OPCTL, 16, 24'h1ba9);
    access(ACC_READ, SEL_RESULT, 24, 24'h0);
    check(rx, 32'habcdef);
    $display("test result done");
  endtask

  task automatic t_cont();
    conv_sample <= 24'h123456;
    access(ACC_WRITE, SEL_OPCTL, 16, 24'h3ba9);
    period();
    period();
    access(ACC_CONT_START, SEL_RESULT, 24, 24'h0);
    check(rx, 32'h123456);
    arf_host_inst.xfer(32'h0, 24, rx);
    check(rx, 32'h123456);
    arf_host_inst.xfer(32'(CMD_CONT_STOP), 24, rx);
    access(ACC_READ, SEL_OPCTL, 16, 24'h0);
    check(rx, 32'h3ba9);
    access(ACC_WRITE, SEL_OPCTL, 16, 24'h1aa9);
    $display("test continuous done");
  endtask

  task automatic t_soft();
    // A single low bit first, so the run of ones is exactly 32 long.
    arf_host_inst.xfer(32'h0, 1, rx);
    arf_host_inst.xfer(32'hffffffff, 32, rx);
    repeat (8) @(posedge ref_clk);
    check(32'(opctl_out), 32'(OPCTL_RESET));
    access(ACC_READ, SEL_FILTER, 24, 24'h0);
    check(rx, 32'(FILTER_RESET));
    $display("test soft reset done");
  endtask

  // Reset for four cycles, then run the tests in turn.
  initial
  begin
    mismatches = 0;
    compares = 0;
    rst = 1'b1;
    ref_missing_pin = 1'b0;
    conv_sample = 24'h0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_regs();
    t_rate();
    t_result();
    t_cont();
    t_soft();
    end_sim();
  end

  // Cuts a hang short, well past the expected length of the run.
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end
endmodule
